/* include/mbs_pkg.sv */
// mbs_pkg: register map, field positions, reset values and timing for the
// modem and battery status block.
// assumes: 8-bit register port with a 3-bit word address, 25 MHz clock.
package mbs_pkg;

	// clock and timing
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned IRQ_PERIOD_S = 1;
	localparam int unsigned SEC_CYCLES = CLK_HZ * IRQ_PERIOD_S;

	// register port
	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned FCT_W = 16;

	// register word addresses
	localparam logic [ADDR_W-1:0] ADR_MODEM_STATE = 3'h0;
	localparam logic [ADDR_W-1:0] ADR_CHARGER_STATE = 3'h1;
	localparam logic [ADDR_W-1:0] ADR_CONTROL = 3'h2;
	localparam logic [ADDR_W-1:0] ADR_WARN_LEVEL = 3'h3;
	localparam logic [ADDR_W-1:0] ADR_SLEEP_LEVEL = 3'h4;
	localparam logic [ADDR_W-1:0] ADR_BATT_LEVEL = 3'h5;
	localparam logic [ADDR_W-1:0] ADR_FCT_LO = 3'h6;
	localparam logic [ADDR_W-1:0] ADR_FCT_HI = 3'h7;

	// modem state byte fields
	localparam int unsigned MS_POWERED = 0;
	localparam int unsigned MS_ALWAYS_ONE = 1;
	localparam int unsigned MS_RING_WAKE = 2;
	localparam int unsigned MS_PRESENT = 3;
	localparam int unsigned MS_CALL_SEEN = 4;
	localparam int unsigned MS_LINE_SEIZED = 5;

	// charger state byte fields
	localparam int unsigned CS_ATTACHED = 0;
	localparam int unsigned CS_FAST = 1;
	localparam int unsigned CS_OVERFLOW = 2;
	localparam int unsigned CS_EXHAUSTED = 3;
	localparam int unsigned CS_WARNING = 4;
	localparam int unsigned CS_LINK_CHANGED = 5;

	// control register fields
	localparam int unsigned CTL_MODEM_POWER = 0;
	localparam int unsigned CTL_RING_WAKE = 1;

	// reset values and fast-charge timer limit
	localparam logic [DATA_W-1:0] RST_CONTROL = 8'h00;
	localparam logic [DATA_W-1:0] RST_WARN_LEVEL = 8'h80;
	localparam logic [DATA_W-1:0] RST_SLEEP_LEVEL = 8'h60;
	localparam logic [FCT_W-1:0] FCT_MAX = 16'hFFFF;

	typedef enum logic [1:0] {
		MBS_CHG_OFF,
		MBS_CHG_FAST_RISE,
		MBS_CHG_FAST_HOLD,
		MBS_CHG_TRICKLE
	} mbs_chg_e;

endpackage : mbs_pkg

/* hdl/mbs_sync.sv */
// mbs_sync: two-flop synchroniser for a bundle of pin levels.
// assumes: each bit is an independent level; no bus coherency is implied.
`timescale 1ns/100ps
module mbs_sync #(
	parameter int unsigned W = 1
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule : mbs_sync

/* hdl/mbs_top.sv */
// mbs_top: modem and battery status bytes, charge sequencing, low-battery policy.
// assumes: modem, charger and battery level come from pins; 8-bit register port.
//
// Behaviour
// R1: modem byte bit 1 reads one; bits 6 and 7 reserved, read zero.
// R2: modem byte bit 0 shows modem power.
// R3: modem byte bit 2 shows ring wakeup enable.
// R4: modem byte bit 3 shows modem presence.
// R5: modem byte bit 4 set when an incoming call is detected.
// R6: modem byte bit 5 shows modem off hook (busy).
// R7: no incoming call accepted or signalled while off hook.
// R8: accepted call with ring wakeup enabled wakes a sleeping system.
// R9: warn below upper threshold, force sleep below lower threshold.
// R10: charger byte bit 0 shows charger attached; bits 6, 7 read zero.
// R11: charger byte bit 1 shows fast charging.
// R12: charger byte bit 2 shows fast-charge timer overflow.
// R13: charger byte bit 3 always reads zero.
// R14: charger byte bit 4 shows battery below warning threshold.
// R15: while battery low, interrupt pulse once per second.
// R16: charger byte bit 5 set on charger attach or detach.
// R17: attaching charger to low battery starts fast charge until full.
// R18: fast-charge timer counts time to reach full voltage.
// R19: after full, fast charge continues until timer counts to zero, then trickle.
// R20: link-changed bit clears when charger byte is read.
`timescale 1ns/100ps
module mbs_top
	import mbs_pkg::*;
#(
	parameter int unsigned SEC_CNT = SEC_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [DATA_W-1:0] o_rdata,
	input wire logic i_modem_present,
	input wire logic i_ring,
	input wire logic i_line_seized,
	input wire logic i_charger_attached,
	input wire logic i_full_voltage,
	input wire logic i_system_asleep,
	input wire logic [DATA_W-1:0] i_batt_level,
	output logic o_modem_power,
	output logic o_wake,
	output logic o_force_sleep,
	output logic o_low_batt_irq,
	output logic o_fast_charge,
	output logic o_trickle_charge
);

	// pin synchronisers
	localparam int unsigned PIN_W = 6;
	logic [PIN_W-1:0] pins_s;
	logic [DATA_W-1:0] level_s;

	mbs_sync #(.W(PIN_W)) u_sync_pins (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_async({i_modem_present, i_ring, i_line_seized, i_charger_attached,
			i_full_voltage, i_system_asleep}),
		.o_sync(pins_s)
	);

	mbs_sync #(.W(DATA_W)) u_sync_level (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_async(i_batt_level),
		.o_sync(level_s)
	);

	wire modem_present = pins_s[5];
	wire ring_s = pins_s[4];
	wire line_seized = pins_s[3];
	wire charger_attached = pins_s[2];
	wire full_voltage = pins_s[1];
	wire asleep_s = pins_s[0];

	// registers
	logic [DATA_W-1:0] control_q;
	logic [DATA_W-1:0] warn_level_q;
	logic [DATA_W-1:0] sleep_level_q;
	logic [DATA_W-1:0] rdata_q;
	logic ring_q;
	logic attached_q;
	logic incoming_call_seen_q;
	logic charger_link_changed_q;
	logic fast_charge_timer_overflow_q;
	logic [FCT_W-1:0] fct_q;
	logic [FCT_W-1:0] fct_d;
	logic [31:0] sec_cnt_q;
	logic sec_tick_q;
	logic irq_q;
	logic wake_q;
	logic force_sleep_q;
	logic fast_q;
	logic trickle_q;
	mbs_chg_e chg_q;
	mbs_chg_e chg_d;

	// address decode
	wire wr_control = i_wr && (i_addr == ADR_CONTROL);
	wire wr_warn = i_wr && (i_addr == ADR_WARN_LEVEL);
	wire wr_sleep = i_wr && (i_addr == ADR_SLEEP_LEVEL);
	wire rd_modem = i_rd && (i_addr == ADR_MODEM_STATE);
	wire rd_charger = i_rd && (i_addr == ADR_CHARGER_STATE);

	wire modem_powered = control_q[CTL_MODEM_POWER];
	wire ring_wake_enabled = control_q[CTL_RING_WAKE];

	function automatic logic below(input logic [DATA_W-1:0] lvl,
		input logic [DATA_W-1:0] thr);
		below = lvl < thr;
	endfunction : below

	// battery policy
	wire battery_warning = below(level_s, warn_level_q); // R9 R14
	wire battery_sleep = below(level_s, sleep_level_q); // R9

	// call detection
	wire ring_rise = ring_s && !ring_q;
	wire call_accept = ring_rise && modem_present && modem_powered && !line_seized; // R7
	wire attach_edge = charger_attached != attached_q;

	// status bytes
	wire [DATA_W-1:0] modem_state_byte = {
		2'b00, // R1
		line_seized, // R6
		incoming_call_seen_q, // R5
		modem_present, // R4
		ring_wake_enabled, // R3
		1'b1, // R1
		modem_powered // R2
	};

	wire [DATA_W-1:0] charger_state_byte = {
		2'b00, // R10
		charger_link_changed_q, // R16
		battery_warning, // R14
		1'b0, // R13
		fast_charge_timer_overflow_q, // R12
		fast_q, // R11
		charger_attached // R10
	};

	logic [DATA_W-1:0] rd_mux;
	always_comb begin
		unique case (i_addr)
			ADR_MODEM_STATE: rd_mux = modem_state_byte;
			ADR_CHARGER_STATE: rd_mux = charger_state_byte;
			ADR_CONTROL: rd_mux = {6'b00_0000, control_q[1:0]};
			ADR_WARN_LEVEL: rd_mux = warn_level_q;
			ADR_SLEEP_LEVEL: rd_mux = sleep_level_q;
			ADR_BATT_LEVEL: rd_mux = level_s;
			ADR_FCT_LO: rd_mux = fct_q[7:0];
			ADR_FCT_HI: rd_mux = fct_q[15:8];
		endcase
	end

	// register port
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			control_q <= RST_CONTROL;
			warn_level_q <= RST_WARN_LEVEL;
			sleep_level_q <= RST_SLEEP_LEVEL;
			rdata_q <= '0;
		end else begin
			if (wr_control) begin
				control_q <= {6'b00_0000, i_wdata[1:0]};
			end
			if (wr_warn) begin
				warn_level_q <= i_wdata;
			end
			if (wr_sleep) begin
				sleep_level_q <= i_wdata;
			end
			rdata_q <= i_rd ? rd_mux : '0;
		end
	end

	// sticky event flags, set wins over clear
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ring_q <= 1'b0;
			attached_q <= 1'b0;
			incoming_call_seen_q <= 1'b0;
			charger_link_changed_q <= 1'b0;
		end else begin
			ring_q <= ring_s;
			attached_q <= charger_attached;
			if (call_accept) begin
				incoming_call_seen_q <= 1'b1; // R5
			end else if (rd_modem || line_seized) begin
				incoming_call_seen_q <= 1'b0; // R7
			end
			if (attach_edge) begin
				charger_link_changed_q <= 1'b1; // R16
			end else if (rd_charger) begin
				charger_link_changed_q <= 1'b0; // R20
			end
		end
	end

	// wake and sleep control
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			wake_q <= 1'b0;
			force_sleep_q <= 1'b0;
		end else begin
			wake_q <= call_accept && ring_wake_enabled && asleep_s; // R8
			force_sleep_q <= battery_sleep; // R9
		end
	end

	// one-second tick and low-battery interrupt
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sec_cnt_q <= '0;
			sec_tick_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			if (sec_cnt_q == SEC_CNT - 1) begin
				sec_cnt_q <= '0;
				sec_tick_q <= 1'b1;
			end else begin
				sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
				sec_tick_q <= 1'b0;
			end
			irq_q <= sec_tick_q && battery_warning; // R15
		end
	end

	// charge sequencer
	always_comb begin
		chg_d = chg_q;
		fct_d = fct_q;
		unique case (chg_q)
			MBS_CHG_OFF: begin
				if (charger_attached) begin
					fct_d = '0;
					chg_d = battery_warning ? MBS_CHG_FAST_RISE : MBS_CHG_TRICKLE; // R17
				end
			end
			MBS_CHG_FAST_RISE: begin
				if (full_voltage) begin
					chg_d = MBS_CHG_FAST_HOLD; // R19
				end else if (fct_q == FCT_MAX) begin
					chg_d = MBS_CHG_TRICKLE; // R12
				end else if (sec_tick_q) begin
					fct_d = fct_q + 16'h0001; // R18
				end
			end
			MBS_CHG_FAST_HOLD: begin
				if (fct_q == '0) begin
					chg_d = MBS_CHG_TRICKLE; // R19
				end else if (sec_tick_q) begin
					fct_d = fct_q - 16'h0001; // R19
				end
			end
			MBS_CHG_TRICKLE: begin
				if (battery_warning && !fast_charge_timer_overflow_q) begin
					fct_d = '0;
					chg_d = MBS_CHG_FAST_RISE; // R17
				end
			end
		endcase
		if (!charger_attached) begin
			chg_d = MBS_CHG_OFF;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			chg_q <= MBS_CHG_OFF;
			fct_q <= '0;
			fast_charge_timer_overflow_q <= 1'b0;
			fast_q <= 1'b0;
			trickle_q <= 1'b0;
		end else begin
			chg_q <= chg_d;
			fct_q <= fct_d;
			if (chg_q == MBS_CHG_FAST_RISE && fct_q == FCT_MAX && !full_voltage) begin
				fast_charge_timer_overflow_q <= 1'b1; // R12
			end else if (attach_edge && charger_attached) begin
				fast_charge_timer_overflow_q <= 1'b0;
			end
			fast_q <= (chg_d == MBS_CHG_FAST_RISE) || (chg_d == MBS_CHG_FAST_HOLD); // R11
			trickle_q <= chg_d == MBS_CHG_TRICKLE; // R19
		end
	end

	assign o_rdata = rdata_q;
	assign o_modem_power = control_q[CTL_MODEM_POWER];
	assign o_wake = wake_q;
	assign o_force_sleep = force_sleep_q;
	assign o_low_batt_irq = irq_q;
	assign o_fast_charge = fast_q;
	assign o_trickle_charge = trickle_q;

endmodule : mbs_top

/* verif/mbs_top_sva.sv */
// mbs_top_sva: port checks for the status block.
// assumes: bound to mbs_top with its SEC_CNT.
`timescale 1ns/100ps
module mbs_top_sva
	import mbs_pkg::*;
#(
	parameter int unsigned SEC_CNT = SEC_CYCLES
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [DATA_W-1:0] o_rdata,
	input wire logic i_ring,
	input wire logic i_charger_attached,
	input wire logic i_system_asleep,
	input wire logic o_modem_power,
	input wire logic o_wake,
	input wire logic o_low_batt_irq,
	input wire logic o_fast_charge,
	input wire logic o_trickle_charge
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	logic [1:0] ctl_q;
	logic [31:0] gap_q;
	logic rd_modem_q;
	logic rd_chg_q;
	// control shadow, status reads of the last cycle, cycles since the last irq pulse
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			ctl_q <= RST_CONTROL[1:0];
			gap_q <= 32'hFFFF_FFFF;
			rd_modem_q <= 1'b0;
			rd_chg_q <= 1'b0;
		end else begin
			rd_modem_q <= i_rd && i_addr == ADR_MODEM_STATE;
			rd_chg_q <= i_rd && i_addr == ADR_CHARGER_STATE;
			if (i_wr && i_addr == ADR_CONTROL) ctl_q <= i_wdata[1:0];
			gap_q <= o_low_batt_irq ? 32'h0000_0000 : gap_q + {31'h0, gap_q != 32'hFFFF_FFFF};
		end
	end
	a_modem_fixed_bits: assert property (rd_modem_q |-> o_rdata[1] && o_rdata[7:6] == 2'h0)
		else $error("modem byte fixed bits wrong");
	a_modem_ctl_bits: assert property (rd_modem_q |-> o_rdata[0] == ctl_q[0] && o_rdata[2] == ctl_q[1])
		else $error("modem byte power or ring wake bit wrong");
	a_charger_fixed_bits: assert property (rd_chg_q |-> o_rdata[7:6] == 2'h0 && !o_rdata[3])
		else $error("charger byte fixed bits wrong");
	a_power_follows_ctl: assert property (o_modem_power == ctl_q[CTL_MODEM_POWER])
		else $error("modem power differs from control");
	a_wake_single_pulse: assert property (o_wake |=> !o_wake)
		else $error("wake longer than one cycle");
	a_wake_needs_cause: assert property (o_wake |-> $past(i_system_asleep, 3) && $past(i_ring, 3))
		else $error("wake without ring while asleep");
	a_irq_once_per_sec: assert property (o_low_batt_irq |-> gap_q >= 32'(SEC_CNT - 1))
		else $error("low battery irq too frequent");
	a_charge_mode_excl: assert property (!(o_fast_charge && o_trickle_charge))
		else $error("fast and trickle together");
	a_charge_off_detached: assert property (!i_charger_attached [*5] |-> !o_fast_charge && !o_trickle_charge)
		else $error("charging without charger");
	c_wake: cover property (o_wake);
	c_irq: cover property (o_low_batt_irq);
	c_trickle: cover property (o_trickle_charge);
endmodule : mbs_top_sva

bind mbs_top mbs_top_sva #(.SEC_CNT(SEC_CNT)) sva_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_ring(i_ring), .i_charger_attached(i_charger_attached), .i_system_asleep(i_system_asleep),
	.o_modem_power(o_modem_power), .o_wake(o_wake), .o_low_batt_irq(o_low_batt_irq),
	.o_fast_charge(o_fast_charge), .o_trickle_charge(o_trickle_charge));

/* verif/mbs_host.sv */
// mbs_host: host processor model on the register port.
// assumes: read data stands in the cycle after the read strobe.
`timescale 1ns/100ps
module mbs_host
	import mbs_pkg::*;
(
	input wire logic i_clk,
	input wire logic [DATA_W-1:0] i_rdata,
	output logic [ADDR_W-1:0] o_addr,
	output logic [DATA_W-1:0] o_wdata,
	output logic o_wr,
	output logic o_rd
);
	initial begin
		o_addr = 3'h0;
		o_wdata = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_wdata <= d;
		o_wr <= 1'b1;
		@(posedge i_clk);
		o_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge i_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_clk);
		o_rd <= 1'b0;
		@(posedge i_clk);
		d = i_rdata;
	endtask : rd
endmodule : mbs_host

/* verif/mbs_top_test.sv */
// mbs_top_test: self-checking bench for the status block.
// assumes: SEC_CNT shortened to 16 cycles.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module mbs_top_test
	import mbs_pkg::*;
;
	localparam int unsigned SC = 16;
	logic i_clk = 1'b0, i_rst_n = 1'b0, pres = 1'b0, ring = 1'b0, seized = 1'b0;
	logic attach = 1'b0, full = 1'b0, asleep = 1'b0;
	logic [7:0] batt = 8'h90, rdata, d;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic wr, rd, pwr, wake, fsleep, irq, fast, trickle;
	int n_mismatch = 0, num_checks = 0, n_wake = 0, n_irq = 0, k;
	logic [1:0] r_ctl [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
	logic r_pres [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
	logic [7:0] r_exp [4] = '{8'h02, 8'h0B, 8'h06, 8'h0F};
	always #20 i_clk = ~i_clk;
	mbs_host host_u (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
		.o_wr(wr), .o_rd(rd));
	mbs_top #(.SEC_CNT(SC)) dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_modem_present(pres),
		.i_ring(ring), .i_line_seized(seized), .i_charger_attached(attach),
		.i_full_voltage(full), .i_system_asleep(asleep), .i_batt_level(batt),
		.o_modem_power(pwr), .o_wake(wake), .o_force_sleep(fsleep), .o_low_batt_irq(irq),
		.o_fast_charge(fast), .o_trickle_charge(trickle));
	always @(posedge i_clk) begin
		if (wake === 1'b1) n_wake <= n_wake + 1;
		if (irq === 1'b1) n_irq <= n_irq + 1;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic ring_pulse();
		@(posedge i_clk) ring <= 1'b1;
		repeat (8) @(posedge i_clk);
		ring <= 1'b0;
		repeat (2) @(posedge i_clk);
	endtask : ring_pulse
	initial begin
		repeat (5000) @(posedge i_clk);
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		host_u.rd(ADR_CONTROL, d); `CHK("control", RST_CONTROL, d)
		host_u.rd(ADR_WARN_LEVEL, d); `CHK("warn", RST_WARN_LEVEL, d)
		host_u.rd(ADR_SLEEP_LEVEL, d); `CHK("sleep", RST_SLEEP_LEVEL, d)
		host_u.wr(ADR_BATT_LEVEL, 8'h00);
		host_u.rd(ADR_BATT_LEVEL, d); `CHK("level", 8'h90, d)
		for (int i = 0; i < 4; i++) begin
			host_u.wr(ADR_CONTROL, {6'h00, r_ctl[i]});
			pres <= r_pres[i];
			repeat (4) @(posedge i_clk);
			host_u.rd(ADR_MODEM_STATE, d); `CHK("modem", r_exp[i], d)
			`CHK("power", r_ctl[i][0], pwr)
		end
		@(posedge i_clk) asleep <= 1'b1;
		ring_pulse();
		`CHK("wake", 1, n_wake)
		host_u.rd(ADR_MODEM_STATE, d); `CHK("call", 8'h1F, d)
		host_u.rd(ADR_MODEM_STATE, d); `CHK("call clr", 8'h0F, d)
		@(posedge i_clk) seized <= 1'b1;
		repeat (4) @(posedge i_clk);
		ring_pulse();
		`CHK("no wake", 1, n_wake)
		host_u.rd(ADR_MODEM_STATE, d); `CHK("busy", 8'h2F, d)
		@(posedge i_clk) batt <= 8'h70;
		attach <= 1'b1;
		repeat (6) @(posedge i_clk);
		host_u.rd(ADR_CHARGER_STATE, d); `CHK("chg", 8'h33, d)
		host_u.rd(ADR_CHARGER_STATE, d); `CHK("chg clr", 8'h13, d)
		k = n_irq;
		repeat (4 * SC) @(posedge i_clk);
		`CHK("irqs", 4, n_irq - k)
		batt <= 8'h90;
		full <= 1'b1;
		repeat (4) @(posedge i_clk);
		`CHK("fast hold", 1'b1, fast)
		for (k = 0; k < 400 && trickle !== 1'b1; k++) @(posedge i_clk);
		`CHK("trickle", 2'b01, {fast, trickle})
		host_u.rd(ADR_CHARGER_STATE, d); `CHK("chg trk", 8'h01, d)
		@(posedge i_clk) batt <= 8'h50;
		repeat (4) @(posedge i_clk);
		`CHK("force", 1'b1, fsleep)
		batt <= 8'h90;
		attach <= 1'b0;
		repeat (6) @(posedge i_clk);
		`CHK("off", 2'b00, {fast, trickle})
		host_u.rd(ADR_CHARGER_STATE, d); `CHK("detach", 8'h20, d)
		// mid-run reset with modem power and ring wake still set
		@(posedge i_clk) i_rst_n <= 1'b0;
		repeat (4) @(posedge i_clk);
		i_rst_n <= 1'b1;
		host_u.rd(ADR_CONTROL, d); `CHK("rst ctl", RST_CONTROL, d)
		`CHK("rst pwr", 1'b0, pwr)
		tally_and_finish();
	end
endmodule : mbs_top_test
